// ---- core/dbm_pkg.sv ----
package dbm_pkg;

    // ****************************************************************
    // array geometry
    // ****************************************************************
    localparam int BANK_W    = 3;                    // bank address field width
    localparam int NUM_BANKS = 8;                    // banks in the array
    localparam int ROW_W     = 4;                    // row address bits
    localparam int COL_W     = 3;                    // column address bits at burst of two
    localparam int ADDR_W    = ROW_W + COL_W;        // address pins
    localparam int WORD_W    = COL_W + 1;            // word-in-row bits
    localparam int MEM_AW    = BANK_W + ROW_W + WORD_W;
    localparam int BEAT_MAX  = 8;                    // longest burst
    localparam int PAIR_MAX  = BEAT_MAX / 2;         // longest burst in edge pairs

    // ****************************************************************
    // mode register and command encodings
    // ****************************************************************
    localparam logic [1:0] BURST_CODE_2   = 2'h0;          // burst of two words
    localparam logic [1:0] BURST_CODE_4   = 2'h1;          // burst of four words
    localparam logic [1:0] BURST_CODE_8   = 2'h2;          // burst of eight words
    localparam logic [1:0] BURST_CODE_RST = BURST_CODE_2;  // burst length after reset
    localparam int         MR_BURST_LSB   = 0;             // burst field in address pins
    localparam logic [2:0] ENC_MRS        = 3'h0;          // {select_n, write_n, refresh_n}
    localparam logic [2:0] ENC_WRITE      = 3'h1;
    localparam logic [2:0] ENC_REF        = 3'h2;
    localparam logic [2:0] ENC_READ       = 3'h3;

    // command pins sampled on the rising command clock
    typedef struct packed {
        logic              cs_n;                     // chip select, low active
        logic              we_n;                     // write enable, low active
        logic              ref_n;                    // refresh, low active
        logic [BANK_W-1:0] bank;                     // bank_select_bit0 is bit 0
        logic [ADDR_W-1:0] addr;                     // {row, column}
    } dbm_cmd_t;

    // words per burst for a burst code
    function automatic logic [3:0] dbm_burst_words(input logic [1:0] code);
        case (code)
            BURST_CODE_4: dbm_burst_words = 4'h4;
            BURST_CODE_8: dbm_burst_words = 4'h8;
            default:      dbm_burst_words = 4'h2;
        endcase
    endfunction : dbm_burst_words

    // flat word address; low column bits give way to the beat as bursts grow
    function automatic logic [MEM_AW-1:0] dbm_index(input logic [BANK_W-1:0] bank,
                                                    input logic [ADDR_W-1:0] addr,
                                                    input logic [1:0]        code,
                                                    input logic [2:0]        beat);
        logic [WORD_W-1:0] base;
        logic [WORD_W-1:0] mask;
        base = {addr[COL_W-1:0], 1'b0};
        mask = WORD_W'(dbm_burst_words(code) - 4'h1);
        dbm_index = {bank, addr[ADDR_W-1:COL_W], (base & ~mask) | (WORD_W'(beat) & mask)};
    endfunction : dbm_index

endpackage : dbm_pkg

// ---- core/dbm_ddr_burst_memory_interface.sv ----
`timescale 1ns/1ps
// How it works
// - two data words per clock, both directions
// - read data aligned to free-running read clock
// - commands sampled only on rising command clock
// - write data captured on both clock edges
// - bursts of 2, 4 or 8 words
// - refresh row comes from internal counter
// - eight banks selected by bank field
// - longer bursts use fewer column bits
module dbm_ddr_burst_memory_interface
    import dbm_pkg::*;
#(
    parameter int DATA_W = 9                                 // data pins
) (
    // command clock domain
    input  wire logic              i_mclk,                   // command_clock_true
    input  wire logic              i_rst_n,                  // synchronous reset
    input  wire dbm_cmd_t          i_cmd,                    // command pins
    // write data link
    input  wire logic              i_write_data_clock,       // controller data clock
    input  wire logic              i_wdata_valid,            // word present on this edge
    input  wire logic [DATA_W-1:0] i_wdata,                  // write data pins
    // read data
    output logic                   o_read_data_clock,        // free-running read clock
    output logic [DATA_W-1:0]      o_rdata,                  // read data pins
    output logic                   o_rdata_valid,            // read word present
    // refresh status
    output logic [BANK_W-1:0]      o_refresh_bank,           // last refreshed bank
    output logic [ROW_W-1:0]       o_refresh_row             // last refreshed row
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    typedef enum {ST_IDLE, ST_READ} dbm_state_t;

    logic [DATA_W-1:0] mem [NUM_BANKS * (2 ** (ROW_W + WORD_W))]; // storage
    logic [ROW_W-1:0]  ref_cnt_ff [NUM_BANKS];               // per-bank refresh rows
    logic [DATA_W-1:0] rise_word_ff [PAIR_MAX];              // words on rising edges
    logic [DATA_W-1:0] fall_word_ff [PAIR_MAX];              // words on falling edges

    // link domain state
    logic [1:0]        lrst_meta_ff, lrst_ff;                // reset into link domain
    logic [1:0]        lbl_meta_ff, lbl_ff;                  // burst code into link domain
    logic [1:0]        pidx_ff, nxt_pidx;                    // pair index in burst
    logic              ltog_ff, nxt_ltog;                    // burst-complete toggle
    logic [1:0]        lpairs;                               // pairs per burst, minus one

    // core domain state
    logic              tog_meta_ff, tog_sync_ff, tog_seen_ff; // toggle synchroniser
    logic              commit;                               // write burst arrived
    dbm_state_t        st_ff, nxt_st;                        // read engine
    logic [2:0]        beat_ff, nxt_beat;                    // read beat
    logic [1:0]        burst_ff, nxt_burst;                  // programmed burst code
    logic [BANK_W-1:0] rd_bank_ff, nxt_rd_bank;              // read target bank
    logic [ADDR_W-1:0] rd_addr_ff, nxt_rd_addr;              // read target address
    logic [BANK_W-1:0] wr_bank_ff, nxt_wr_bank;              // write target bank
    logic [ADDR_W-1:0] wr_addr_ff, nxt_wr_addr;              // write target address
    logic              rclk_ff, nxt_rclk;                    // read clock
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;                  // read data
    logic              rvalid_ff, nxt_rvalid;                // read data valid
    logic [BANK_W-1:0] rbank_ff, nxt_rbank;                  // refresh bank status
    logic [ROW_W-1:0]  rrow_ff, nxt_rrow;                    // refresh row status
    logic              is_ref;                               // refresh this cycle
    logic [2:0]        enc;                                  // command pins as code

    // ****************************************************************
    // link side: write data capture
    // ****************************************************************
    // level crossings into the link domain, quasi-static
    // the link clock must run two idle periods before a frame,
    // or a new burst code does not reach this side in time
    always_ff @(posedge i_write_data_clock) begin
        lrst_meta_ff <= {lrst_meta_ff[0], i_rst_n};
        lrst_ff      <= lrst_meta_ff;
        lbl_meta_ff  <= burst_ff;
        lbl_ff       <= lbl_meta_ff;
    end

    // first word of each pair on the rising edge
    always_ff @(posedge i_write_data_clock) begin
        if (i_wdata_valid) begin
            rise_word_ff[pidx_ff] <= i_wdata;
        end
    end

    // pair count and toggle after the last pair
    always_comb begin
        lpairs   = 2'(dbm_burst_words(lbl_ff) / 4'h2 - 4'h1);
        nxt_pidx = pidx_ff;
        nxt_ltog = ltog_ff;
        if (!lrst_ff[1]) begin
            nxt_pidx = 2'h0;
            nxt_ltog = 1'b0;
        end else if (i_wdata_valid) begin
            // burst finished: hand it to the core
            if (pidx_ff == lpairs) begin
                nxt_pidx = 2'h0;
                nxt_ltog = ~ltog_ff;
            end else begin
                nxt_pidx = pidx_ff + 2'h1;
            end
        end
    end

    // second word of each pair on the falling edge
    always_ff @(negedge i_write_data_clock) begin
        if (i_wdata_valid) begin
            fall_word_ff[pidx_ff] <= i_wdata;
        end
        pidx_ff <= nxt_pidx;
        ltog_ff <= nxt_ltog;
    end

    // ****************************************************************
    // core side: burst handover
    // ****************************************************************
    // toggle synchroniser; only the second and third stages are compared
    always_ff @(posedge i_mclk) begin
        tog_meta_ff <= ltog_ff;
        if (!i_rst_n) begin
            tog_sync_ff <= 1'b0;
            tog_seen_ff <= 1'b0;
        end else begin
            tog_sync_ff <= tog_meta_ff;
            tog_seen_ff <= tog_sync_ff;
        end
    end

    assign commit = tog_sync_ff ^ tog_seen_ff;

    // write a whole burst into the array at once
    always_ff @(posedge i_mclk) begin
        if (commit) begin
            for (int i = 0; i < PAIR_MAX; i++) begin
                if (4'(2 * i) < dbm_burst_words(burst_ff)) begin
                    // even beats came on rising edges, odd beats on falling
                    mem[dbm_index(wr_bank_ff, wr_addr_ff, burst_ff, 3'(2 * i))]
                        <= rise_word_ff[i];
                    mem[dbm_index(wr_bank_ff, wr_addr_ff, burst_ff, 3'(2 * i + 1))]
                        <= fall_word_ff[i];
                end
            end
        end
    end

    // ****************************************************************
    // refresh row counters
    // ****************************************************************
    // each bank advances its own row on refresh
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                ref_cnt_ff[b] <= '0;
            end
        end else if (is_ref) begin
            ref_cnt_ff[i_cmd.bank] <= ref_cnt_ff[i_cmd.bank] + 1'b1;
        end
    end

    // ****************************************************************
    // command decode and read engine
    // ****************************************************************
    // next values from the sampled command
    always_comb begin
        enc         = {1'b0, i_cmd.we_n, i_cmd.ref_n};       // same order as the codes
        is_ref      = !i_cmd.cs_n && enc == ENC_REF;
        nxt_st      = st_ff;
        nxt_beat    = beat_ff;
        nxt_burst   = burst_ff;
        nxt_rd_bank = rd_bank_ff;
        nxt_rd_addr = rd_addr_ff;
        nxt_wr_bank = wr_bank_ff;
        nxt_wr_addr = wr_addr_ff;
        nxt_rclk    = ~rclk_ff;
        nxt_rdata   = rdata_ff;
        nxt_rvalid  = 1'b0;
        nxt_rbank   = rbank_ff;
        nxt_rrow    = rrow_ff;
        // commands are decoded only here, once per rising edge
        if (!i_cmd.cs_n) begin
            case (enc)
                ENC_MRS: begin
                    // reserved burst code keeps the old length
                    if (i_cmd.addr[MR_BURST_LSB +: 2] != 2'h3) begin
                        nxt_burst = i_cmd.addr[MR_BURST_LSB +: 2];
                    end
                end
                ENC_WRITE: begin
                    nxt_wr_bank = i_cmd.bank;
                    nxt_wr_addr = i_cmd.addr;
                end
                ENC_REF: begin
                    nxt_rbank = i_cmd.bank;
                    nxt_rrow  = ref_cnt_ff[i_cmd.bank];
                end
                ENC_READ: begin
                    // a read during a burst is ignored
                    if (st_ff == ST_IDLE) begin
                        nxt_st      = ST_READ;
                        nxt_beat    = 3'h0;
                        nxt_rd_bank = i_cmd.bank;
                        nxt_rd_addr = i_cmd.addr;
                    end
                end
                default: begin
                end
            endcase
        end
        // one word per command clock edge, two per read clock period
        case (st_ff)
            ST_READ: begin
                nxt_rdata  = mem[dbm_index(rd_bank_ff, rd_addr_ff, burst_ff,
                                           beat_ff)];
                nxt_rvalid = 1'b1;
                nxt_beat   = beat_ff + 3'h1;
                if (4'(beat_ff) == dbm_burst_words(burst_ff) - 4'h1) begin
                    nxt_st = ST_IDLE;
                end
            end
            default: begin
                nxt_st = (nxt_st == ST_READ) ? ST_READ : ST_IDLE;
            end
        endcase
    end

    // register the core state
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            st_ff      <= ST_IDLE;
            beat_ff    <= 3'h0;
            burst_ff   <= BURST_CODE_RST;
            rd_bank_ff <= '0;
            rd_addr_ff <= '0;
            wr_bank_ff <= '0;
            wr_addr_ff <= '0;
            rclk_ff    <= 1'b0;
            rdata_ff   <= '0;
            rvalid_ff  <= 1'b0;
            rbank_ff   <= '0;
            rrow_ff    <= '0;
        end else begin
            st_ff      <= nxt_st;
            beat_ff    <= nxt_beat;
            burst_ff   <= nxt_burst;
            rd_bank_ff <= nxt_rd_bank;
            rd_addr_ff <= nxt_rd_addr;
            wr_bank_ff <= nxt_wr_bank;
            wr_addr_ff <= nxt_wr_addr;
            rclk_ff    <= nxt_rclk;
            rdata_ff   <= nxt_rdata;
            rvalid_ff  <= nxt_rvalid;
            rbank_ff   <= nxt_rbank;
            rrow_ff    <= nxt_rrow;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign o_read_data_clock = rclk_ff;
    assign o_rdata           = rdata_ff;
    assign o_rdata_valid     = rvalid_ff;
    assign o_refresh_bank    = rbank_ff;
    assign o_refresh_row     = rrow_ff;

endmodule : dbm_ddr_burst_memory_interface

// ---- verification/dbm_ddr_burst_memory_interface_props.sv ----
`timescale 1ns/1ps
// ********************************
// read and refresh checks
// ********************************
module dbm_ddr_burst_memory_interface_props
    import dbm_pkg::*;
#(
    parameter int DATA_W = 9                  // data pins
) (
    // command side
    input logic              i_mclk,
    input logic              i_rst_n,
    input dbm_cmd_t          i_cmd,
    // read and refresh outputs
    input logic              o_read_data_clock,
    input logic [DATA_W-1:0] o_rdata,
    input logic              o_rdata_valid,
    input logic [BANK_W-1:0] o_refresh_bank,
    input logic [ROW_W-1:0]  o_refresh_row
);
    logic       rd_cmd;                       // read taken this edge
    logic       rf_cmd;                       // refresh taken this edge
    logic [3:0] run_len_ff;                   // length of current valid run
    logic [3:0] nxt_run_len;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    assign rd_cmd = !i_cmd.cs_n && i_cmd.we_n && i_cmd.ref_n;
    assign rf_cmd = !i_cmd.cs_n && i_cmd.we_n && !i_cmd.ref_n;

    // counts the words of each burst
    always_comb begin
        nxt_run_len = o_rdata_valid ? run_len_ff + 4'h1 : 4'h0;
    end
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            run_len_ff <= 4'h0;
        end else begin
            run_len_ff <= nxt_run_len;
        end
    end

    // read arriving on an idle data bus
    sequence s_idle_read;
        rd_cmd && !o_rdata_valid && !$past(rd_cmd);
    endsequence
    // two idle cycles, then at least two words
    sequence s_burst_out;
        ##2 o_rdata_valid [*2];
    endsequence

    AST_READ_LATENCY: assert property (s_idle_read |-> s_burst_out)
        else $error("read burst did not start two cycles after the read");
    AST_BURST_LENGTH: assert property ($fell(o_rdata_valid) |-> run_len_ff inside {4'h2, 4'h4, 4'h8})
        else $error("read burst length is not two, four or eight");
    AST_VALID_CAUSE: assert property ($rose(o_rdata_valid) |-> $past(rd_cmd, 2))
        else $error("read data appeared without a read two cycles before");
    AST_NO_SPURIOUS: assert property (!o_rdata_valid && !rd_cmd && !$past(rd_cmd) |=> !o_rdata_valid)
        else $error("read data valid rose with no read pending");
    AST_READ_CLOCK: assert property ($past(i_rst_n) |-> o_read_data_clock != $past(o_read_data_clock))
        else $error("read clock missed a toggle");
    AST_RDATA_HOLD: assert property (!o_rdata_valid && $past(!o_rdata_valid) |-> $stable(o_rdata))
        else $error("read data moved outside a burst");
    AST_REFRESH_BANK: assert property (rf_cmd |=> o_refresh_bank == $past(i_cmd.bank))
        else $error("refresh bank does not match the command");
    AST_REFRESH_HOLD: assert property (!rf_cmd |=> $stable(o_refresh_bank) && $stable(o_refresh_row))
        else $error("refresh status changed without a refresh");
endmodule : dbm_ddr_burst_memory_interface_props

bind dbm_ddr_burst_memory_interface dbm_ddr_burst_memory_interface_props #(.DATA_W(DATA_W)) u_props (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cmd(i_cmd), .o_read_data_clock(o_read_data_clock),
    .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid), .o_refresh_bank(o_refresh_bank),
    .o_refresh_row(o_refresh_row)
);

// ---- verification/dbm_link_ctrl_model.sv ----
`timescale 1ns/1ps
// ********************************
// controller end of the write link
// ********************************
module dbm_link_ctrl_model
    import dbm_pkg::*;
#(
    parameter int DATA_W = 9                  // data pins
) (
    // write link toward the device
    output logic              o_write_data_clock,
    output logic              o_wdata_valid,
    output logic [DATA_W-1:0] o_wdata
);
    // link parked: clock low, nothing valid
    initial begin
        o_write_data_clock = 1'b0;
        o_wdata_valid      = 1'b0;
        o_wdata            = '0;
    end

    // one word per link edge, 12 ns period, clock runs only in a frame
    task automatic send_burst(input int n, input logic [DATA_W-1:0] seed, input logic v);
        // two idle periods lead each frame so the burst code settles at the far end
        for (int i = 0; i < 4; i++) begin
            o_wdata_valid      = 1'b0;
            #3;
            o_write_data_clock = ~o_write_data_clock;
            #3;
        end
        for (int i = 0; i < n; i++) begin
            o_wdata_valid      = v;
            o_wdata            = seed + DATA_W'(i);
            #3;
            o_write_data_clock = ~o_write_data_clock;
            #3;
        end
        // released lines show the inverse of the last word
        o_wdata_valid = 1'b0;
        o_wdata       = ~o_wdata;
    endtask : send_burst
endmodule : dbm_link_ctrl_model

// ---- verification/dbm_ddr_burst_memory_interface_tb_top.sv ----
`timescale 1ns/1ps
// ********************************
// burst memory interface bench
// ********************************
module dbm_ddr_burst_memory_interface_tb_top
    import dbm_pkg::*;
;
    localparam int DW = 9;
    typedef struct packed {
        logic [1:0]        code;              // burst code
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] wa;                // write address
        logic [ADDR_W-1:0] ra;                // read address, may alias
        logic [DW-1:0]     seed;              // first word of burst
    } dbm_row_t;

    logic              i_mclk  = 1'b0;
    logic              i_rst_n = 1'b0;
    dbm_cmd_t          i_cmd   = '1;          // deselected
    logic              lclk, wvld, rclk, rvld;
    logic [DW-1:0]     wdat, rdata;
    logic [BANK_W-1:0] rbank;
    logic [ROW_W-1:0]  rrow;
    int                n_errors, total_checks;
    dbm_row_t          rows [4] = '{
        '{2'h0, 3'h0, 7'h12, 7'h12, 9'h011},  // shortest burst
        '{2'h1, 3'h5, 7'h25, 7'h24, 9'h1A0},  // column bit 0 dropped
        '{2'h2, 3'h7, 7'h7B, 7'h78, 9'h0F0},  // column bits 1:0 dropped
        '{2'h0, 3'h3, 7'h12, 7'h12, 9'h1FE}   // same place, other bank
    };

    dbm_ddr_burst_memory_interface #(.DATA_W(DW)) u_dut (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cmd(i_cmd), .i_write_data_clock(lclk),
        .i_wdata_valid(wvld), .i_wdata(wdat), .o_read_data_clock(rclk), .o_rdata(rdata),
        .o_rdata_valid(rvld), .o_refresh_bank(rbank), .o_refresh_row(rrow)
    );
    dbm_link_ctrl_model #(.DATA_W(DW)) u_ctrl (
        .o_write_data_clock(lclk), .o_wdata_valid(wvld), .o_wdata(wdat)
    );

    always #20 i_mclk = ~i_mclk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // command held for one rising edge, then deselect
    task automatic cmd(input logic we_n, input logic ref_n, input logic [2:0] b, input logic [6:0] a);
        @(posedge i_mclk);
        i_cmd <= {1'b0, we_n, ref_n, b, a};
        @(posedge i_mclk);
        i_cmd <= '1;
    endtask : cmd

    // read, then expect n words from the second cycle on
    task automatic rd_chk(input logic [2:0] b, input logic [6:0] a, input int n, input logic [DW-1:0] s);
        cmd(1'b1, 1'b1, b, a);
        @(posedge i_mclk);
        #1;
        for (int i = 0; i < n; i++) begin
            chk(16'(rvld), 16'h0001);
            chk(16'(rdata), 16'(s + DW'(i)));
            @(posedge i_mclk);
            #1;
        end
        chk(16'(rvld), 16'h0000);
    endtask : rd_chk

    task automatic close_out;
        $display("checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    initial begin
        int n;
        int hits;
        u_ctrl.send_burst(4, '0, 1'b0);                      // link edges inside reset
        repeat (14) @(posedge i_mclk);
        #1;
        chk(16'({rvld, rbank, rrow}), 16'h0000);
        @(posedge i_mclk);
        i_rst_n <= 1'b1;
        u_ctrl.send_burst(4, '0, 1'b0);                      // idle edges after release
        // write a burst, read it back, for bursts of two, four and eight; four and eight through an aliased column
        foreach (rows[k]) begin
            n = int'(4'h2 << rows[k].code);
            cmd(1'b0, 1'b0, 3'h0, 7'(rows[k].code));
            cmd(1'b0, 1'b1, rows[k].bank, rows[k].wa);
            u_ctrl.send_burst(n, rows[k].seed, 1'b1);
            repeat (8) @(posedge i_mclk);
            rd_chk(rows[k].bank, rows[k].ra, n, rows[k].seed);
        end
        rd_chk(3'h0, 7'h12, 2, 9'h011);
        // refresh rows come from a per-bank counter
        for (int j = 0; j < 3; j++) begin
            cmd(1'b1, 1'b0, (j == 2) ? 3'h2 : 3'h6, 7'h7F);
            @(posedge i_mclk);
            #1;
            chk(16'({rbank, rrow}), (j == 2) ? 16'h0020 : 16'h0060 | 16'(j));
        end
        // undefined burst code leaves four in force
        cmd(1'b0, 1'b0, 3'h0, 7'h01);
        cmd(1'b0, 1'b0, 3'h0, 7'h03);
        rd_chk(3'h5, 7'h24, 4, 9'h1A0);
        // read issued during a burst is dropped
        cmd(1'b0, 1'b0, 3'h0, 7'h02);
        cmd(1'b1, 1'b1, 3'h7, 7'h78);
        cmd(1'b1, 1'b1, 3'h3, 7'h12);
        hits = 0;
        repeat (12) begin
            @(posedge i_mclk);
            #1;
            hits += (rvld === 1'b1) ? 1 : 0;
        end
        chk(16'(hits), 16'h0006);
        close_out();
    end

    // cuts a hang short
    initial begin
        #60000;
        n_errors++;
        close_out();
    end
endmodule : dbm_ddr_burst_memory_interface_tb_top
